// *** alsf_status.sv ***
// alu status flag register with alu, watchdog flags and apb access
`include "alsf_regs.svh"

module alsf_status
  import alsf_pkg::*;
(
  input wire logic CORE_CLK, // core clock, 10 MHz
  input wire logic RESETN, // async reset, active low
  input wire logic OP_VALID, // operation strobe
  input wire alsf_op_type OP, // operation and operands
  output logic RESULT_VALID, // result strobe
  output logic [7:0] RESULT, // result byte
  input wire logic WDT_TIMEOUT, // watchdog expired pulse
  input wire logic SLEEP_EXEC, // sleep executed pulse
  input wire logic CLRWDT_EXEC, // watchdog clear pulse
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb enable
  input wire logic PWRITE, // apb direction
  input wire logic [11:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  input wire logic [3:0] PSTRB, // apb byte strobes
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR // apb error
);

  // ======================================================================
  // state
  logic [4:0] flags_reg;
  logic [4:0] flags_next;
  logic to_reg;
  logic pd_reg;
  logic [7:0] result_reg;
  logic result_valid_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  wire [7:0] status_rd = {1'b0, to_reg, pd_reg, flags_reg};

  // ======================================================================
  // operand selection and arithmetic
  wire [7:0] op_a = OP.src_status ? status_rd : OP.opnd_a;
  wire c_in = flags_reg[`ALSF_BIT_C];
  wire is_sub = (OP.opcode == ALSF_OP_SUB) || (OP.opcode == ALSF_OP_SUBB);
  wire [7:0] op_b = is_sub ? ~OP.opnd_b : OP.opnd_b;
  wire add_cin = (OP.opcode == ALSF_OP_SUB) ? 1'b1 :
                 ((OP.opcode == ALSF_OP_ADDC) || (OP.opcode == ALSF_OP_SUBB)) ? c_in : 1'b0;
  wire [8:0] sum9 = {1'b0, op_a} + {1'b0, op_b} + {8'h00, add_cin};
  wire [4:0] sum_lo = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, add_cin};
  wire add_ov = (op_a[7] == op_b[7]) && (sum9[7] != op_a[7]);
  wire [7:0] bit_mask = 8'h01 << OP.bit_sel;

  logic [7:0] alu_res;
  logic [4:0] new_flags;
  logic [4:0] upd_mask;
  logic zn_from_res;

  always_comb begin
    alu_res = 8'h00;
    new_flags = flags_reg;
    upd_mask = 5'h00;
    zn_from_res = 1'b0;
    unique case (OP.opcode)
      ALSF_OP_ADD, ALSF_OP_ADDC, ALSF_OP_SUB, ALSF_OP_SUBB: begin
        alu_res = sum9[7:0];
        new_flags[`ALSF_BIT_C] = sum9[8];
        new_flags[`ALSF_BIT_DC] = sum_lo[4];
        new_flags[`ALSF_BIT_OV] = add_ov;
        upd_mask = 5'h1f;
        zn_from_res = 1'b1;
      end
      ALSF_OP_AND: begin
        alu_res = op_a & OP.opnd_b;
        zn_from_res = 1'b1;
      end
      ALSF_OP_IOR: begin
        alu_res = op_a | OP.opnd_b;
        zn_from_res = 1'b1;
      end
      ALSF_OP_XOR: begin
        alu_res = op_a ^ OP.opnd_b;
        zn_from_res = 1'b1;
      end
      ALSF_OP_RLC: begin
        alu_res = {op_a[6:0], c_in};
        new_flags[`ALSF_BIT_C] = op_a[7];
        upd_mask[`ALSF_BIT_C] = 1'b1;
        zn_from_res = 1'b1;
      end
      ALSF_OP_RRC: begin
        alu_res = {c_in, op_a[7:1]};
        new_flags[`ALSF_BIT_C] = op_a[0];
        upd_mask[`ALSF_BIT_C] = 1'b1;
        zn_from_res = 1'b1;
      end
      ALSF_OP_CLR: begin
        alu_res = 8'h00;
        new_flags[`ALSF_BIT_Z] = 1'b1;
        upd_mask[`ALSF_BIT_Z] = 1'b1;
      end
      ALSF_OP_BCLR: alu_res = op_a & ~bit_mask;
      ALSF_OP_BSET: alu_res = op_a | bit_mask;
      ALSF_OP_SWAP: alu_res = {op_a[3:0], op_a[7:4]};
      ALSF_OP_FILE_TO_FILE_MOVE_INSTR: alu_res = op_a;
      ALSF_OP_WREG_TO_FILE_MOVE_INSTR: alu_res = OP.opnd_b;
      default: alu_res = 8'h00;
    endcase
    if (zn_from_res) begin
      new_flags[`ALSF_BIT_N] = alu_res[7];
      new_flags[`ALSF_BIT_Z] = (alu_res == 8'h00);
      upd_mask[`ALSF_BIT_N] = 1'b1;
      upd_mask[`ALSF_BIT_Z] = 1'b1;
    end
  end

  // ======================================================================
  // flag register write selection; an alu op that writes flags or targets the flag register wins over an apb write
  wire apb_setup = PSEL && !PENABLE;
  wire apb_access = PSEL && PENABLE;
  wire hit_status = (PADDR == `ALSF_STATUS_OFFSET);
  wire hit_result = (PADDR == `ALSF_RESULT_OFFSET);
  wire apb_wr_status = apb_access && PWRITE && hit_status && PSTRB[0];
  wire op_sets_flags = OP_VALID && (upd_mask != 5'h00);
  wire op_to_status = OP_VALID && OP.dest_status;

  always_comb begin
    flags_next = flags_reg;
    if (op_to_status && (upd_mask != 5'h00)) begin
      flags_next = new_flags;
    end else if (op_to_status) begin
      flags_next = alu_res[4:0];
    end else if (op_sets_flags) begin
      flags_next = new_flags;
    end else if (apb_wr_status) begin
      flags_next = PWDATA[4:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      flags_reg <= `ALSF_FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ======================================================================
  // timeout and powerdown: hardware owned, never written by software
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      to_reg <= 1'b1;
      pd_reg <= 1'b1;
    end else if (WDT_TIMEOUT) begin
      to_reg <= 1'b0;
    end else if (CLRWDT_EXEC) begin
      to_reg <= 1'b1;
      pd_reg <= 1'b1;
    end else if (SLEEP_EXEC) begin
      to_reg <= 1'b1;
      pd_reg <= 1'b0;
    end
  end

  // ======================================================================
  // result output; discarded whenever the operation targets the flag register
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      result_reg <= 8'h00;
      result_valid_reg <= 1'b0;
    end else begin
      result_valid_reg <= OP_VALID && !OP.dest_status;
      if (OP_VALID && !OP.dest_status) begin
        result_reg <= alu_res;
      end
    end
  end

  assign RESULT = result_reg;
  assign RESULT_VALID = result_valid_reg;

  // ======================================================================
  // apb read data captured in the setup cycle, zero wait answer
  wire [31:0] rd_mux = hit_status ? {24'h000000, status_rd} :
                       hit_result ? {24'h000000, result_reg} : 32'h00000000;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else if (apb_setup) begin
      prdata_reg <= rd_mux;
      pslverr_reg <= !(hit_status || hit_result) || (PWRITE && hit_result);
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = apb_access && pslverr_reg;

  // ======================================================================
  // checks
  default clocking chk_cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  wire plain_op = OP_VALID && !OP.src_status;

  chk_clear_zero_only: assert property (
    (OP_VALID && OP.dest_status && OP.opcode == ALSF_OP_CLR) |=>
      (flags_reg == {$past(flags_reg[4:3]), 1'b1, $past(flags_reg[1:0])}))
    else $error("clear of flag register changed more than zero");

  chk_dest_discard: assert property (
    (plain_op && OP.dest_status && OP.opcode == ALSF_OP_ADD) |=>
      (!RESULT_VALID && flags_reg[0] == ($past({1'b0, OP.opnd_a}) + $past({1'b0, OP.opnd_b}) > 9'h0ff)))
    else $error("add into flag register did not take flags only");

  chk_move_intact: assert property (
    (OP_VALID && OP.dest_status && OP.opcode == ALSF_OP_WREG_TO_FILE_MOVE_INSTR) |=>
      (flags_reg == $past(OP.opnd_b[4:0])))
    else $error("move into flag register not stored intact");

  chk_bitop_keeps: assert property (
    (OP_VALID && !OP.dest_status && OP.opcode == ALSF_OP_BSET && !apb_wr_status) |=>
      $stable(flags_reg))
    else $error("bit set altered a flag");

  chk_sub_borrow: assert property (
    (plain_op && !OP.dest_status && OP.opcode == ALSF_OP_SUB) |=>
      (flags_reg[0] == ($past(OP.opnd_a) >= $past(OP.opnd_b))))
    else $error("subtract carry is not the inverted borrow");

  chk_neg_zero: assert property (
    (OP_VALID && !OP.dest_status && OP.opcode == ALSF_OP_XOR) |=>
      (flags_reg[4] == RESULT[7] && flags_reg[2] == (RESULT == 8'h00)))
    else $error("negative or zero flag disagrees with result");

  chk_rotate_carry: assert property (
    (plain_op && !OP.dest_status && OP.opcode == ALSF_OP_RLC) |=>
      (flags_reg[0] == $past(OP.opnd_a[7]) && RESULT[0] == $past(flags_reg[0])))
    else $error("rotate left did not pass bits through carry");

  chk_readonly_bits: assert property (
    (apb_wr_status && !WDT_TIMEOUT && !SLEEP_EXEC && !CLRWDT_EXEC) |=>
      ($stable(to_reg) && $stable(pd_reg)))
    else $error("software write reached timeout or powerdown");

  chk_unimpl_zero: assert property (
    (apb_setup && hit_status) |=> (PRDATA[31:7] == 25'h0))
    else $error("unimplemented status bits read nonzero");

  chk_apb_write: assert property (
    (apb_wr_status && !OP_VALID) |=> (flags_reg == $past(PWDATA[4:0])))
    else $error("apb write to flag register lost");

  cov_sub_dest: cover property (OP_VALID && OP.dest_status && is_sub);
  cov_clear_status: cover property (OP_VALID && OP.dest_status && OP.opcode == ALSF_OP_CLR);
  cov_ov_set: cover property (OP_VALID && add_ov && upd_mask[3]);
  cov_sleep_read: cover property (SLEEP_EXEC ##2 (apb_setup && hit_status));

endmodule

// *** alsf_regs.svh ***
// register offsets, field positions, reset values of the alu status flag block
`ifndef ALSF_REGS_SVH
`define ALSF_REGS_SVH

// ======================================================================
// register map
`define ALSF_ADDR_W 12
`define ALSF_STATUS_OFFSET 12'h000
`define ALSF_RESULT_OFFSET 12'h004

// ======================================================================
// flag register fields
`define ALSF_BIT_C 0
`define ALSF_BIT_DC 1
`define ALSF_BIT_Z 2
`define ALSF_BIT_OV 3
`define ALSF_BIT_N 4
`define ALSF_BIT_PD 5
`define ALSF_BIT_TO 6
`define ALSF_FLAGS_RESET 5'h00
`define ALSF_STATUS_RESET 8'h60

`endif

// *** alsf_pkg.sv ***
// types of the alu status flag block
package alsf_pkg;

  // ======================================================================
  // operations that the core hands to the alu
  typedef enum logic [3:0] {
    ALSF_OP_ADD   = 4'h0,
    ALSF_OP_ADDC  = 4'h1,
    ALSF_OP_SUB   = 4'h2,
    ALSF_OP_SUBB  = 4'h3,
    ALSF_OP_AND   = 4'h4,
    ALSF_OP_IOR   = 4'h5,
    ALSF_OP_XOR   = 4'h6,
    ALSF_OP_RLC   = 4'h7,
    ALSF_OP_RRC   = 4'h8,
    ALSF_OP_CLR   = 4'h9,
    ALSF_OP_BCLR  = 4'ha,
    ALSF_OP_BSET  = 4'hb,
    ALSF_OP_SWAP  = 4'hc,
    ALSF_OP_FILE_TO_FILE_MOVE_INSTR = 4'hd,
    ALSF_OP_WREG_TO_FILE_MOVE_INSTR = 4'he
  } alsf_opcode_type;

  // ======================================================================
  // one operation request
  typedef struct packed {
    alsf_opcode_type opcode;
    logic src_status;
    logic dest_status;
    logic [2:0] bit_sel;
    logic [7:0] opnd_a;
    logic [7:0] opnd_b;
  } alsf_op_type;

endpackage

// *** tb.sv ***
// self-checking testbench of the alu status flag block
module tb;
  import alsf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, rstn, opv, wdt, slp, clr, psel, pen, pwr, rv, prdy, perr, er;
  alsf_op_type op;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [7:0] res;
  int fail_count, n_tests;

  alsf_status uut (.CORE_CLK(clk), .RESETN(rstn), .OP_VALID(opv), .OP(op),
    .RESULT_VALID(rv), .RESULT(res), .WDT_TIMEOUT(wdt), .SLEEP_EXEC(slp),
    .CLRWDT_EXEC(clr), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(prdy), .PSLVERR(perr));

  always #50 clk = ~clk;

  // ======================================================================
  // reporting
  task print_verdict;
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ======================================================================
  // apb master: setup, then access until pready at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      if (prdy === 1'b1) break;
    end
    if (i == 8) begin
      fail_count++;
      print_verdict;
    end
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task rs(input logic [7:0] st);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, {24'h0, st});
  endtask

  // ======================================================================
  // one operation, then result strobe, result byte and flag register
  task opr(input alsf_opcode_type c, input logic s, input logic d, input logic [2:0] b,
           input logic [7:0] x, input logic [7:0] y, input logic v, input logic [7:0] r,
           input logic [7:0] st);
    @(posedge clk);
    opv <= 1'b1;
    op <= '{c, s, d, b, x, y};
    @(posedge clk);
    opv <= 1'b0;
    #1;
    chk({31'h0, rv}, {31'h0, v});
    chk({24'h0, res}, {24'h0, r});
    @(posedge clk);
    #1;
    chk({31'h0, rv}, 32'h0);
    rs(st);
  endtask

  task pulse(input int k, input logic [7:0] st);
    @(posedge clk);
    if (k == 0) wdt <= 1'b1;
    else if (k == 1) slp <= 1'b1;
    else clr <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    slp <= 1'b0;
    clr <= 1'b0;
    rs(st);
  endtask

  // ======================================================================
  // main sequence
  initial begin
    clk = 0;
    rstn = 0;
    opv = 0;
    op = '0;
    wdt = 0;
    slp = 0;
    clr = 0;
    psel = 0;
    pen = 0;
    pwr = 0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h1;
    fail_count = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rs(8'h60);
    opr(ALSF_OP_ADD, 0, 0, 0, 8'h7f, 8'h01, 1, 8'h80, 8'h7a);
    opr(ALSF_OP_SUB, 0, 0, 0, 8'h05, 8'h05, 1, 8'h00, 8'h67);
    opr(ALSF_OP_SUB, 0, 0, 0, 8'h00, 8'h01, 1, 8'hff, 8'h70);
    opr(ALSF_OP_ADD, 0, 0, 0, 8'hff, 8'h01, 1, 8'h00, 8'h67);
    opr(ALSF_OP_RLC, 0, 0, 0, 8'h80, 8'h00, 1, 8'h01, 8'h63);
    opr(ALSF_OP_RRC, 0, 0, 0, 8'h01, 8'h00, 1, 8'h80, 8'h73);
    opr(ALSF_OP_CLR, 0, 1, 0, 8'h00, 8'h00, 0, 8'h80, 8'h77);
    opr(ALSF_OP_ADD, 0, 1, 0, 8'h01, 8'h01, 0, 8'h80, 8'h60);
    opr(ALSF_OP_WREG_TO_FILE_MOVE_INSTR, 0, 1, 0, 8'h00, 8'h1f, 0, 8'h80, 8'h7f);
    opr(ALSF_OP_FILE_TO_FILE_MOVE_INSTR, 0, 1, 0, 8'h0a, 8'h00, 0, 8'h80, 8'h6a);
    opr(ALSF_OP_SWAP, 0, 1, 0, 8'ha5, 8'h00, 0, 8'h80, 8'h7a);
    opr(ALSF_OP_BSET, 0, 1, 3, 8'h00, 8'h00, 0, 8'h80, 8'h68);
    opr(ALSF_OP_BCLR, 0, 1, 0, 8'h1f, 8'h00, 0, 8'h80, 8'h7e);
    opr(ALSF_OP_AND, 1, 0, 0, 8'h00, 8'hff, 1, 8'h7e, 8'h6a);
    apb(1'b1, 12'h000, 32'hff);
    rs(8'h7f);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h7e);
    chk({31'h0, er}, 32'h0);
    chk({31'h0, prdy}, 32'h1);
    apb(1'b1, 12'h004, 32'hff);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    opr(ALSF_OP_ADDC, 0, 0, 0, 8'h0e, 8'h00, 1, 8'h0f, 8'h60);
    opr(ALSF_OP_SUBB, 0, 0, 0, 8'h10, 8'h00, 1, 8'h0f, 8'h61);
    pulse(0, 8'h21);
    pulse(1, 8'h41);
    pulse(2, 8'h61);
    opr(ALSF_OP_XOR, 0, 0, 0, 8'hf0, 8'hf0, 1, 8'h00, 8'h65);
    opr(ALSF_OP_IOR, 0, 0, 0, 8'h80, 8'h01, 1, 8'h81, 8'h71);
    opr(ALSF_OP_BSET, 0, 0, 2, 8'h00, 8'h00, 1, 8'h04, 8'h71);
    opr(ALSF_OP_SUB, 0, 1, 0, 8'h00, 8'h01, 0, 8'h04, 8'h70);
    pstrb <= 4'h0;
    apb(1'b1, 12'h000, 32'h1f);
    chk({31'h0, er}, 32'h0);
    rs(8'h70);
    print_verdict;
  end
endmodule
